// >>> fault_bank_consts.svh
`ifndef FAULT_BANK_CONSTS_SVH
`define FAULT_BANK_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_LIVE_ONE 8'h00
`define OFS_LIVE_TWO 8'h01
`define OFS_LIVE_THREE 8'h02
`define OFS_STICKY_ONE 8'h04
`define OFS_STICKY_TWO 8'h05
`define OFS_STICKY_THREE 8'h06

// ----------------------------------------
// Field positions, first fault register
// ----------------------------------------
`define B1_SUPPLY_OFF 7
`define B1_ISO_OFF 6
`define B1_PG_ONE 5
`define B1_PG_TWO 4
`define B1_RECT_OFF 3
`define B1_PRI_FAST 2
`define B1_PRI_ACC 1
`define B1_SEC_ACC 0

// ----------------------------------------
// Field positions, second fault register
// ----------------------------------------
`define B2_CONTINUITY 7
`define B2_LOCAL_UV 6
`define B2_REVERSE 5
`define B2_SUPPLY_UV 4
`define B2_CORE_OV 3
`define B2_SUPPLY_OV 2
`define B2_LOAD_OV 1
`define B2_LOCAL_OV 0

// ----------------------------------------
// Field positions, third fault register
// ----------------------------------------
`define B3_OVER_TEMP 7
`define B3_RSVD_HI 6
`define B3_SHARE 5
`define B3_CONST_CUR 4
`define B3_RSVD_LO 3
`define B3_LINE_IMP 2
`define B3_SOFT_FILT 1
`define B3_EXT_FAULT 0

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define PG2_SRC_W 17
`define ASYNC_W 20
`define BYTE_ZERO 8'h00
`define SUPPLY_OFF_RST 1'b1

`endif

// >>> fault_bank_pkg.sv
package fault_bank_pkg;
   typedef logic [7:0] fault_byte_t;
   typedef logic [16:0] pg2_vec_t;
   typedef logic [19:0] async_vec_t;
endpackage

// >>> sticky_flags.sv
`timescale 1ns/1ps
`include "fault_bank_consts.svh"

module sticky_flags (
   input wire logic MCLK,
   input wire logic RST,
   input wire fault_bank_pkg::fault_byte_t live,
   input wire logic clr,
   output fault_bank_pkg::fault_byte_t flags
);

   fault_bank_pkg::fault_byte_t prev_ff;
   fault_bank_pkg::fault_byte_t flags_ff;
   fault_bank_pkg::fault_byte_t rise;
   fault_bank_pkg::fault_byte_t drop;
   fault_bank_pkg::fault_byte_t nxt_flags;

   // ----------------------------------------
   // Edge capture and clear on read
   // ----------------------------------------
   assign rise = live & ~prev_ff;
   assign drop = clr ? ~live : `BYTE_ZERO;
   assign nxt_flags = (flags_ff & ~drop) | rise;
   assign flags = flags_ff;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         prev_ff <= `BYTE_ZERO;
         flags_ff <= `BYTE_ZERO;
      end else begin
         prev_ff <= live;
         flags_ff <= nxt_flags;
      end
   end

endmodule // sticky_flags

// >>> fault_status_latch_bank.sv
`timescale 1ns/1ps
`include "fault_bank_consts.svh"

// Overview of operation
// - Latched flags stay set after their fault condition goes away.
// - Only a host read clears a latched flag, unless fault persists.
// - Latched flags set only on a rising edge of the live flag.
// - Live and latched registers share layouts; one means fault.
// - Supply-off bit set with outputs disabled until supply restarts.
// - Isolation-switch bit set while its gate control is off.
// - Power-ok-one fault is OR of seven supply and protection flags.
// - Power-ok-two fault is OR of wider individually maskable flags.
// - Rectifier-off bit: user disable, light load or flag action.
// - Fast primary overcurrent bit follows its comparator.
// - Accurate primary and secondary overcurrent bits.
// - Local undervoltage bit; response programmable elsewhere.
// - Reverse voltage bit; isolation switch disabled.
// - Supply undervoltage or core overvoltage force immediate shutdown.
// - Supply overvoltage needs a power-on toggle to restart.
// - Remote load overvoltage and local overvoltage bits.
// - Overtemperature and current-share bits; bits 6 and 3 reserved.
// - Constant-current bit, no protective action.
// - Line impedance bit, no action.
// - Soft-start filter in use bit, no action.
// - External fault input bit; response programmable elsewhere.
module fault_status_latch_bank (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic RD_STB,
   input wire logic [7:0] RD_ADDR,
   output logic [7:0] RD_DATA,
   output logic RD_VALID,
   input wire logic PRI_FAST_OC,
   input wire logic PRI_ACC_OC,
   input wire logic SEC_ACC_OC,
   input wire logic CONTINUITY_FAULT,
   input wire logic LOCAL_UV,
   input wire logic REVERSE_V,
   input wire logic SUPPLY_UV,
   input wire logic CORE_RAIL_OV,
   input wire logic SUPPLY_OV,
   input wire logic REMOTE_A_OV,
   input wire logic REMOTE_B_OV,
   input wire logic LOCAL_OV,
   input wire logic OVER_TEMP,
   input wire logic SHARE_FAULT,
   input wire logic CONST_CURRENT,
   input wire logic LINE_IMPEDANCE,
   input wire logic SOFT_START_FILTER,
   input wire logic EXTERNAL_FAULT_INPUT,
   input wire logic ISOLATION_GATE_ON,
   input wire logic POWER_ON_INPUT,
   input wire logic LINE_SENSE_FAULT,
   input wire logic CHECKSUM_FAULT,
   input wire logic STORE_UNLOCKED,
   input wire logic SHUTDOWN_REQ,
   input wire logic RESTART_REQ,
   input wire logic RECT_USER_OFF,
   input wire logic LIGHT_LOAD,
   input wire logic RECT_FLAG_OFF,
   input wire fault_bank_pkg::pg2_vec_t PG2_IGNORE,
   output logic SUPPLY_OFF,
   output logic POWER_OK_ONE_FAULT,
   output logic POWER_OK_TWO_FAULT,
   output logic RECT_OFF
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   fault_bank_pkg::async_vec_t raw;
   fault_bank_pkg::async_vec_t meta_ff;
   fault_bank_pkg::async_vec_t sync_ff;

   assign raw = {PRI_FAST_OC, PRI_ACC_OC, SEC_ACC_OC, CONTINUITY_FAULT,
                 LOCAL_UV, REVERSE_V, SUPPLY_UV, CORE_RAIL_OV, SUPPLY_OV,
                 REMOTE_A_OV, REMOTE_B_OV, LOCAL_OV, OVER_TEMP, SHARE_FAULT,
                 CONST_CURRENT, LINE_IMPEDANCE, SOFT_START_FILTER,
                 EXTERNAL_FAULT_INPUT, ISOLATION_GATE_ON, POWER_ON_INPUT};

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= raw;
         sync_ff <= meta_ff;
      end
   end

   // ----------------------------------------
   // Named synchronised conditions
   // ----------------------------------------
   logic pri_fast;
   logic pri_acc;
   logic sec_acc;
   logic continuity;
   logic local_uv;
   logic reverse_v;
   logic supply_uv;
   logic core_ov;
   logic supply_ov;
   logic load_ov;
   logic local_ov;
   logic over_temp;
   logic share;
   logic const_cur;
   logic line_imp;
   logic soft_filt;
   logic ext_fault;
   logic iso_off;
   logic power_on;

   assign pri_fast = sync_ff[19];
   assign pri_acc = sync_ff[18];
   assign sec_acc = sync_ff[17];
   assign continuity = sync_ff[16];
   assign local_uv = sync_ff[15];
   assign reverse_v = sync_ff[14];
   assign supply_uv = sync_ff[13];
   assign core_ov = sync_ff[12];
   assign supply_ov = sync_ff[11];
   assign load_ov = sync_ff[10] | sync_ff[9];
   assign local_ov = sync_ff[8];
   assign over_temp = sync_ff[7];
   assign share = sync_ff[6];
   assign const_cur = sync_ff[5];
   assign line_imp = sync_ff[4];
   assign soft_filt = sync_ff[3];
   assign ext_fault = sync_ff[2];
   assign iso_off = ~sync_ff[1];
   assign power_on = sync_ff[0];

   // ----------------------------------------
   // Supply off tracking
   // ----------------------------------------
   logic supply_off_ff;
   logic ov_lock_ff;
   logic power_on_prev_ff;
   logic hard_trip;
   logic power_on_rise;
   logic restart;
   logic nxt_supply_off;
   logic nxt_ov_lock;

   assign hard_trip = supply_uv | core_ov | supply_ov;
   assign power_on_rise = power_on & ~power_on_prev_ff;
   assign restart = (RESTART_REQ & ~ov_lock_ff) | power_on_rise;
   assign nxt_supply_off = hard_trip | SHUTDOWN_REQ |
                           (supply_off_ff & ~restart);
   assign nxt_ov_lock = supply_ov | (ov_lock_ff & power_on);

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         supply_off_ff <= `SUPPLY_OFF_RST;
         ov_lock_ff <= 1'b0;
         power_on_prev_ff <= 1'b0;
      end else begin
         supply_off_ff <= nxt_supply_off;
         ov_lock_ff <= nxt_ov_lock;
         power_on_prev_ff <= power_on;
      end
   end

   // ----------------------------------------
   // Aggregated flags
   // ----------------------------------------
   fault_bank_pkg::pg2_vec_t pg2_src;
   logic pg_one;
   logic pg_two;
   logic rect_off;

   assign pg_one = supply_off_ff | pri_fast | pri_acc | sec_acc |
                   local_uv | local_ov | load_ov;
   assign pg2_src = {supply_off_ff, iso_off, pri_fast, pri_acc, sec_acc,
                     continuity, local_uv, reverse_v, LINE_SENSE_FAULT,
                     ext_fault, core_ov, supply_ov, local_ov, load_ov,
                     over_temp, CHECKSUM_FAULT, STORE_UNLOCKED};
   assign pg_two = |(pg2_src & ~PG2_IGNORE);
   assign rect_off = RECT_USER_OFF | LIGHT_LOAD | RECT_FLAG_OFF;

   // ----------------------------------------
   // Live registers
   // ----------------------------------------
   fault_bank_pkg::fault_byte_t live_one_ff;
   fault_bank_pkg::fault_byte_t live_two_ff;
   fault_bank_pkg::fault_byte_t live_three_ff;
   fault_bank_pkg::fault_byte_t nxt_live_one;
   fault_bank_pkg::fault_byte_t nxt_live_two;
   fault_bank_pkg::fault_byte_t nxt_live_three;

   always_comb begin
      nxt_live_one = `BYTE_ZERO;
      nxt_live_one[`B1_SUPPLY_OFF] = supply_off_ff;
      nxt_live_one[`B1_ISO_OFF] = iso_off;
      nxt_live_one[`B1_PG_ONE] = pg_one;
      nxt_live_one[`B1_PG_TWO] = pg_two;
      nxt_live_one[`B1_RECT_OFF] = rect_off;
      nxt_live_one[`B1_PRI_FAST] = pri_fast;
      nxt_live_one[`B1_PRI_ACC] = pri_acc;
      nxt_live_one[`B1_SEC_ACC] = sec_acc;
   end

   always_comb begin
      nxt_live_two = `BYTE_ZERO;
      nxt_live_two[`B2_CONTINUITY] = continuity;
      nxt_live_two[`B2_LOCAL_UV] = local_uv;
      nxt_live_two[`B2_REVERSE] = reverse_v;
      nxt_live_two[`B2_SUPPLY_UV] = supply_uv;
      nxt_live_two[`B2_CORE_OV] = core_ov;
      nxt_live_two[`B2_SUPPLY_OV] = supply_ov;
      nxt_live_two[`B2_LOAD_OV] = load_ov;
      nxt_live_two[`B2_LOCAL_OV] = local_ov;
   end

   always_comb begin
      nxt_live_three = `BYTE_ZERO;
      nxt_live_three[`B3_OVER_TEMP] = over_temp;
      nxt_live_three[`B3_RSVD_HI] = 1'b0;
      nxt_live_three[`B3_SHARE] = share;
      nxt_live_three[`B3_CONST_CUR] = const_cur;
      nxt_live_three[`B3_RSVD_LO] = 1'b0;
      nxt_live_three[`B3_LINE_IMP] = line_imp;
      nxt_live_three[`B3_SOFT_FILT] = soft_filt;
      nxt_live_three[`B3_EXT_FAULT] = ext_fault;
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         live_one_ff <= `BYTE_ZERO;
         live_two_ff <= `BYTE_ZERO;
         live_three_ff <= `BYTE_ZERO;
      end else begin
         live_one_ff <= nxt_live_one;
         live_two_ff <= nxt_live_two;
         live_three_ff <= nxt_live_three;
      end
   end

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   function automatic logic addr_is(input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   logic sel_l1;
   logic sel_l2;
   logic sel_l3;
   logic sel_s1;
   logic sel_s2;
   logic sel_s3;
   logic hit_s1;
   logic hit_s2;
   logic hit_s3;

   assign sel_l1 = addr_is(RD_ADDR, `OFS_LIVE_ONE);
   assign sel_l2 = addr_is(RD_ADDR, `OFS_LIVE_TWO);
   assign sel_l3 = addr_is(RD_ADDR, `OFS_LIVE_THREE);
   assign sel_s1 = addr_is(RD_ADDR, `OFS_STICKY_ONE);
   assign sel_s2 = addr_is(RD_ADDR, `OFS_STICKY_TWO);
   assign sel_s3 = addr_is(RD_ADDR, `OFS_STICKY_THREE);
   assign hit_s1 = RD_STB & sel_s1;
   assign hit_s2 = RD_STB & sel_s2;
   assign hit_s3 = RD_STB & sel_s3;

   // ----------------------------------------
   // Latched copies, same layout as live
   // ----------------------------------------
   fault_bank_pkg::fault_byte_t sticky_one;
   fault_bank_pkg::fault_byte_t sticky_two;
   fault_bank_pkg::fault_byte_t sticky_three;

   sticky_flags u_sticky_one (
      .MCLK(MCLK),
      .RST(RST),
      .live(live_one_ff),
      .clr(hit_s1),
      .flags(sticky_one)
   );

   sticky_flags u_sticky_two (
      .MCLK(MCLK),
      .RST(RST),
      .live(live_two_ff),
      .clr(hit_s2),
      .flags(sticky_two)
   );

   sticky_flags u_sticky_three (
      .MCLK(MCLK),
      .RST(RST),
      .live(live_three_ff),
      .clr(hit_s3),
      .flags(sticky_three)
   );

   // ----------------------------------------
   // Read data mux, no side effect on live
   // ----------------------------------------
   fault_bank_pkg::fault_byte_t rd_mux;

   assign rd_mux = sel_l1 ? live_one_ff :
                   sel_l2 ? live_two_ff :
                   sel_l3 ? live_three_ff :
                   sel_s1 ? sticky_one :
                   sel_s2 ? sticky_two :
                   sel_s3 ? sticky_three :
                   `BYTE_ZERO;

   // ----------------------------------------
   // Read port registers
   // ----------------------------------------
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RD_DATA <= `BYTE_ZERO;
         RD_VALID <= 1'b0;
      end else begin
         RD_DATA <= RD_STB ? rd_mux : RD_DATA;
         RD_VALID <= RD_STB;
      end
   end

   // ----------------------------------------
   // Status output registers
   // ----------------------------------------
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         SUPPLY_OFF <= `SUPPLY_OFF_RST;
         POWER_OK_ONE_FAULT <= 1'b0;
         POWER_OK_TWO_FAULT <= 1'b0;
         RECT_OFF <= 1'b0;
      end else begin
         SUPPLY_OFF <= supply_off_ff;
         POWER_OK_ONE_FAULT <= pg_one;
         POWER_OK_TWO_FAULT <= pg_two;
         RECT_OFF <= rect_off;
      end
   end

endmodule // fault_status_latch_bank

// >>> fault_bank_host.sv
`timescale 1ns/1ps
module fault_bank_host (
   input wire logic MCLK,
   output logic RD_STB,
   output logic [7:0] RD_ADDR
);
   // ----------------
   // Byte reads
   // ----------------
   initial begin
      RD_STB = 1'b0;
      RD_ADDR = 8'h00;
   end
   // One read per call, back to back allowed
   task automatic rd(input logic [7:0] a);
      RD_STB = 1'b1;
      RD_ADDR = a;
      @(posedge MCLK);
      #1;
   endtask
   // Release, address no longer meaningful
   task automatic idle();
      RD_STB = 1'b0;
      RD_ADDR = ~RD_ADDR;
   endtask
endmodule // fault_bank_host

// >>> fault_status_latch_bank_asserts.sv
`timescale 1ns/1ps
module fault_status_latch_bank_asserts (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic RD_STB,
   input wire logic [7:0] RD_ADDR,
   input wire logic [7:0] RD_DATA,
   input wire logic RD_VALID,
   input wire logic SUPPLY_OV,
   input wire logic POWER_ON_INPUT,
   input wire logic SHUTDOWN_REQ,
   input wire logic RESTART_REQ,
   input wire logic RECT_USER_OFF,
   input wire logic LIGHT_LOAD,
   input wire logic RECT_FLAG_OFF,
   input wire logic SUPPLY_OFF,
   input wire logic POWER_OK_ONE_FAULT,
   input wire logic RECT_OFF
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // ----------------
   // Cycles since a restart cause
   // ----------------
   logic [3:0] since_ff;
   logic pon_ff;
   wire logic rect_req = RECT_USER_OFF | LIGHT_LOAD | RECT_FLAG_OFF;
   wire logic cause = RESTART_REQ | (POWER_ON_INPUT ^ pon_ff);
   wire logic [3:0] nxt_since = cause ? 4'h0 :
      since_ff + 4'(since_ff != 4'hf);
   wire logic mapped = RD_ADDR inside {8'h00, 8'h01, 8'h02, 8'h04,
      8'h05, 8'h06};
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         since_ff <= 4'hf;
         pon_ff <= 1'b0;
      end else begin
         since_ff <= nxt_since;
         pon_ff <= POWER_ON_INPUT;
      end
   end
   // ----------------
   // Properties
   // ----------------
   AST_READ_ANSWER: assert property (RD_STB |=> RD_VALID)
      else $error("read not answered");
   AST_VALID_PULSE: assert property (!RD_STB |=> !RD_VALID)
      else $error("read answer without request");
   AST_UNMAPPED: assert property (
      RD_STB && !mapped |=> RD_DATA == 8'h00)
      else $error("unmapped read not zero");
   AST_RESERVED: assert property (RD_STB && (RD_ADDR == 8'h02 ||
      RD_ADDR == 8'h06) |=> !RD_DATA[6] && !RD_DATA[3])
      else $error("reserved bit set");
   AST_DATA_HOLD: assert property (
      !RD_VALID |-> $stable(RD_DATA))
      else $error("read data moved");
   AST_RECT_SET: assert property (rect_req[*4] |-> RECT_OFF)
      else $error("rectifier off missing");
   AST_SHUTDOWN: assert property (
      $rose(SHUTDOWN_REQ) |-> ##[1:3] SUPPLY_OFF)
      else $error("shutdown not seen");
   AST_OFF_CAUSE: assert property (
      $fell(SUPPLY_OFF) |-> since_ff < 4'h8)
      else $error("supply off dropped alone");
   AST_OV_OFF: assert property (SUPPLY_OV[*8] |-> SUPPLY_OFF)
      else $error("overvoltage left supply on");
   AST_PG1_OFF: assert property (
      SUPPLY_OFF[*6] |-> POWER_OK_ONE_FAULT)
      else $error("power ok one missing");
endmodule // fault_status_latch_bank_asserts

bind fault_status_latch_bank fault_status_latch_bank_asserts chk_i (
   .MCLK(MCLK), .RST(RST), .RD_STB(RD_STB), .RD_ADDR(RD_ADDR),
   .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .SUPPLY_OV(SUPPLY_OV),
   .POWER_ON_INPUT(POWER_ON_INPUT), .SHUTDOWN_REQ(SHUTDOWN_REQ),
   .RESTART_REQ(RESTART_REQ), .RECT_USER_OFF(RECT_USER_OFF),
   .LIGHT_LOAD(LIGHT_LOAD), .RECT_FLAG_OFF(RECT_FLAG_OFF),
   .SUPPLY_OFF(SUPPLY_OFF), .POWER_OK_ONE_FAULT(POWER_OK_ONE_FAULT),
   .RECT_OFF(RECT_OFF));

// >>> tb_fault_status_latch_bank.sv
`timescale 1ns/1ps
module tb_fault_status_latch_bank;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic [19:0] c = 20'h40000;
   logic [7:0] d = 8'h00;
   fault_bank_pkg::pg2_vec_t ign = 17'h00000;
   logic stb, rvalid, soff, pg1, pg2, roff, sup = 1'b1;
   logic [7:0] addr, rdata, msk = 8'h00;
   logic [7:0] lv [3] = '{default: 8'h00};
   logic [7:0] st [3] = '{default: 8'h00};
   logic [15:0] q [$];
   logic [15:0] e;
   int fail_count = 0;
   int comparisons = 0;

   always #2.5 MCLK = ~MCLK;

   fault_bank_host fault_bank_host_i (.MCLK(MCLK), .RD_STB(stb),
      .RD_ADDR(addr));
   fault_status_latch_bank fault_status_latch_bank_i (
      .MCLK(MCLK), .RST(RST), .RD_STB(stb), .RD_ADDR(addr),
      .RD_DATA(rdata), .RD_VALID(rvalid), .PRI_FAST_OC(c[0]),
      .PRI_ACC_OC(c[1]), .SEC_ACC_OC(c[2]), .CONTINUITY_FAULT(c[3]),
      .LOCAL_UV(c[4]), .REVERSE_V(c[5]), .SUPPLY_UV(c[6]),
      .CORE_RAIL_OV(c[7]), .SUPPLY_OV(c[8]), .REMOTE_A_OV(c[9]),
      .REMOTE_B_OV(c[10]), .LOCAL_OV(c[11]), .OVER_TEMP(c[12]),
      .SHARE_FAULT(c[13]), .CONST_CURRENT(c[14]),
      .LINE_IMPEDANCE(c[15]), .SOFT_START_FILTER(c[16]),
      .EXTERNAL_FAULT_INPUT(c[17]), .ISOLATION_GATE_ON(c[18]),
      .POWER_ON_INPUT(c[19]), .LINE_SENSE_FAULT(d[0]),
      .CHECKSUM_FAULT(d[1]), .STORE_UNLOCKED(d[2]), .SHUTDOWN_REQ(d[3]),
      .RESTART_REQ(d[4]), .RECT_USER_OFF(d[5]), .LIGHT_LOAD(d[6]),
      .RECT_FLAG_OFF(d[7]), .PG2_IGNORE(ign), .SUPPLY_OFF(soff),
      .POWER_OK_ONE_FAULT(pg1), .POWER_OK_TWO_FAULT(pg2),
      .RECT_OFF(roff));

   // ----------------
   // Compare and read helpers
   // ----------------
   task automatic chk(string n, logic [7:0] ex, logic [7:0] g);
      comparisons++;
      if (g !== ex) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, ex, g);
      end
   endtask

   task automatic rdx(logic [7:0] a, logic [7:0] ex, logic [7:0] m);
      q.push_back({m, ex});
      fault_bank_host_i.rd(a);
   endtask

   task automatic pulse(int b);
      d[b] = 1'b1;
      @(posedge MCLK);
      #1;
      d[b] = 1'b0;
   endtask

   // Model the registers, wait, check outputs, read everything
   task automatic settle();
      logic [16:0] src;
      logic [7:0] n [3];
      src = {sup, !c[18], c[0], c[1], c[2], c[3], c[4], c[5], d[0],
         c[17], c[7], c[8], c[11], c[9] | c[10], c[12], d[1], d[2]};
      n[0] = {sup, !c[18], sup | (|c[2:0]) | c[4] | (|c[11:9]),
         |(src & ~ign), |d[7:5], c[0], c[1], c[2]};
      n[1] = {c[3], c[4], c[5], c[6], c[7], c[8], c[9] | c[10], c[11]};
      n[2] = {c[12], 1'b0, c[13], c[14], 1'b0, c[15], c[16], c[17]};
      for (int k = 0; k < 3; k++) begin
         st[k] = st[k] | (n[k] & ~lv[k]);
         lv[k] = n[k];
      end
      repeat (10) @(posedge MCLK);
      #1;
      chk("SUPPLY_OFF", 8'(sup), 8'(soff));
      chk("PG_ONE", 8'(n[0][5]), 8'(pg1));
      chk("PG_TWO", 8'(n[0][4]), 8'(pg2));
      chk("RECT_OFF", 8'(n[0][3]), 8'(roff));
      for (int k = 0; k < 3; k++) begin
         rdx(8'(k), lv[k], 8'hff);
         rdx(8'(k + 4), st[k], msk);
         st[k] = st[k] & lv[k];
      end
      rdx(8'h03, 8'h00, 8'hff);
      rdx(8'($urandom_range(255, 7)), 8'h00, 8'hff);
      fault_bank_host_i.idle();
      repeat (2) @(posedge MCLK);
      #1;
      chk("PENDING", 8'h00, 8'(q.size()));
   endtask

   // ----------------
   // Read result monitor
   // ----------------
   always @(negedge MCLK) begin
      if (rvalid === 1'b1) begin
         if (q.size() > 0) begin
            e = q.pop_front();
            chk("RD_DATA", e[7:0] & e[15:8], rdata & e[15:8]);
         end else begin
            chk("RD_VALID", 8'h00, 8'h01);
         end
      end
   end

   // ----------------
   // Tests
   // ----------------
   initial begin
      void'($urandom(80));
      repeat (8) @(posedge MCLK);
      #1;
      RST = 1'b0;
      settle();
      c[19] = 1'b1;
      sup = 1'b0;
      settle();
      msk = 8'hff;
      $display("test startup done");
      for (int k = 6; k < 9; k++) begin
         c[k] = 1'b1;
         sup = 1'b1;
         settle();
         c[k] = 1'b0;
         settle();
         pulse(4);
         sup = (k == 8);
         settle();
      end
      c[19] = 1'b0;
      settle();
      c[19] = 1'b1;
      sup = 1'b0;
      settle();
      pulse(3);
      sup = 1'b1;
      settle();
      pulse(4);
      sup = 1'b0;
      settle();
      $display("test supply off done");
      for (int i = 0; i < 20; i++) begin
         d = 8'($urandom) & 8'he7;
         ign = 17'($urandom);
         settle();
         c = 20'($urandom) & 20'h7fe3f | 20'h80000;
         settle();
      end
      $display("test random faults done");
      conclude();
   end

   // Tests take about 1100 cycles
   initial begin
      #100000;
      fail_count++;
      conclude();
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
endmodule // tb_fault_status_latch_bank
